// file: design/amc_mode_control_port.sv
`default_nettype none
module amc_mode_control_port #(
  parameter int SLEEP_RECOVER_CYCLES = amc_pkg::SLEEP_RECOVER_CYCLES,
  parameter int NAP_RECOVER_CYCLES = amc_pkg::NAP_RECOVER_CYCLES,
  parameter int SOFT_SLEEP_CYCLES = amc_pkg::SOFT_SLEEP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic port_style_select_i,
  input wire logic group_one_select_n_i,
  input wire logic group_two_select_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic [7:0][13:0] adc_code_i,
  output logic [7:0][13:0] data_o,
  output amc_pkg::amc_cfg_s [1:0] group_cfg_o,
  output logic [7:0] channel_ready_o
);
  localparam int WAKE_MAX = (SLEEP_RECOVER_CYCLES > NAP_RECOVER_CYCLES) ?
    SLEEP_RECOVER_CYCLES : NAP_RECOVER_CYCLES;
  localparam int WAKE_W = $clog2(WAKE_MAX + 1);
  localparam int SOFT_W = $clog2(SOFT_SLEEP_CYCLES + 1);
  localparam logic [4:0] CNT_FULL = 5'(amc_pkg::FRAME_BITS);
  localparam logic [4:0] CNT_ADDR = 5'(amc_pkg::FRAME_BITS / 2);

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic par_s;
  logic cs1_n_s;
  logic cs2_n_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_s;
  logic sck_prev_reg;
  logic frame_prev_reg;

  // reset values match the idle pins: selects high, clock and data low
  amc_sync #(.WIDTH(6), .RST_VAL(6'h18)) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i({port_style_select_i, group_one_select_n_i, group_two_select_n_i,
          sclk_i, sdata_i, sdo_i}),
    .q_o({par_s, cs1_n_s, cs2_n_s, sck_s, sdi_s, sdo_s})
  );

  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;
  // strapped mode turns the port off entirely
  wire frame_act = ~par_s & (~cs1_n_s | ~cs2_n_s);
  wire frame_start = frame_act & ~frame_prev_reg;
  wire frame_end = ~frame_act & frame_prev_reg;

  // edge history
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_prev_reg <= 1'b0;
      frame_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      frame_prev_reg <= frame_act;
    end
  end

  // ****************************************
  // serial frame engine
  // ****************************************
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic rd_reg;
  logic rd_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic [7:0] rd_data;

  wire take_bit = frame_act & sck_rise & (cnt_reg < CNT_FULL);
  wire [6:0] rd_addr = {rx_reg[5:0], sdi_s};
  wire rd_cmd = rx_reg[6];
  wire addr_done = take_bit & (cnt_reg == CNT_ADDR - 5'h01);
  wire shift_out = frame_act & rd_reg & sck_fall &
                   (cnt_reg >= CNT_ADDR) & (cnt_reg < CNT_FULL);

  // bit counter, receive shifter and group select
  assign cnt_next = frame_start ? 5'h00 : take_bit ? cnt_reg + 5'h01 : cnt_reg;
  assign rx_next = take_bit ? {rx_reg[14:0], sdi_s} : rx_reg;
  assign sel_next = frame_start ? {~cs2_n_s, ~cs1_n_s} : sel_reg;
  // readback loads once the address is known
  assign rd_next = frame_start ? 1'b0 : addr_done ? rd_cmd : rd_reg;
  assign tx_next = (addr_done & rd_cmd) ? rd_data :
                   shift_out ? {tx_reg[6:0], 1'b0} : tx_reg;
  // open drain: enable only to pull low, released between frames
  assign oe_n_next = ~frame_act ? 1'b1 :
                     shift_out ? tx_reg[7] : oe_n_reg;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
      sel_reg <= 2'h0;
      rd_reg <= 1'b0;
      tx_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      sel_reg <= sel_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign sdo_o = 1'b0;
  assign sdo_oe_n_o = oe_n_reg;

  // ****************************************
  // mode register sets
  // ****************************************
  logic [7:0] mode_reg [amc_pkg::NUM_GRP][amc_pkg::NUM_MODE];
  logic [1:0] soft_rst;
  logic [SOFT_W-1:0] soft_cnt_reg [amc_pkg::NUM_GRP];

  wire [6:0] wr_addr = rx_reg[14:8];
  wire [7:0] wr_data = rx_reg[7:0];
  // commit only a complete write frame, at its end
  wire wr_ok = frame_end & (cnt_reg == CNT_FULL) & ~rx_reg[15];
  wire wr_map = (wr_addr >= amc_pkg::ADDR_FORMAT) & (wr_addr <= amc_pkg::ADDR_PAT_LO);
  wire [1:0] wr_idx = 2'(wr_addr - amc_pkg::ADDR_FORMAT);
  wire rd_map = (rd_addr >= amc_pkg::ADDR_FORMAT) & (rd_addr <= amc_pkg::ADDR_PAT_LO);
  wire [1:0] rd_idx = 2'(rd_addr - amc_pkg::ADDR_FORMAT);
  wire rd_grp = ~sel_reg[0];
  // reset register and unmapped addresses read as zero
  assign rd_data = rd_map ? mode_reg[rd_grp][rd_idx] : 8'h00;

  amc_pkg::amc_cfg_s [1:0] cfg_next;
  amc_pkg::amc_cfg_s [1:0] cfg_reg;

  genvar g;
  generate
    for (g = 0; g < amc_pkg::NUM_GRP; g++) begin : g_grp
      wire [7:0] fmt = mode_reg[g][amc_pkg::IDX_FORMAT];
      wire [7:0] om = mode_reg[g][amc_pkg::IDX_OUTMODE];
      wire [7:0] phi = mode_reg[g][amc_pkg::IDX_PAT_HI];
      wire [7:0] plo = mode_reg[g][amc_pkg::IDX_PAT_LO];
      wire [2:0] cur_code = par_s ? (sck_s ? amc_pkg::CUR_1P75 : amc_pkg::CUR_3P5) :
                            om[amc_pkg::OM_CUR_MSB:amc_pkg::OM_CUR_LSB];
      wire term = par_s ? sdo_s : om[amc_pkg::OM_TERM_BIT];
      wire [9:0] cur_base = amc_pkg::amc_current(cur_code);
      wire [2:0] lane = par_s ? (cs1_n_s ? amc_pkg::LANE_1_14 : amc_pkg::LANE_2_16) :
                        om[amc_pkg::OM_LANE_MSB:0];
      wire soft_sleep = (soft_cnt_reg[g] != '0);

      assign soft_rst[g] = wr_ok & sel_reg[g] & (wr_addr == amc_pkg::ADDR_RESET) &
                           wr_data[amc_pkg::RESET_BIT];

      // register writes; soft reset clears the whole set
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          for (int r = 0; r < amc_pkg::NUM_MODE; r++) begin
            mode_reg[g][r] <= amc_pkg::MODE_RESET_VAL;
          end
        end else begin
          for (int r = 0; r < amc_pkg::NUM_MODE; r++) begin
            if (soft_rst[g]) begin
              mode_reg[g][r] <= amc_pkg::MODE_RESET_VAL;
            end else if (wr_ok & sel_reg[g] & wr_map & (wr_idx == 2'(r))) begin
              mode_reg[g][r] <= wr_data;
            end
          end
        end
      end

      // momentary sleep after soft reset
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          soft_cnt_reg[g] <= '0;
        end else if (soft_rst[g]) begin
          soft_cnt_reg[g] <= SOFT_W'(SOFT_SLEEP_CYCLES);
        end else if (soft_sleep) begin
          soft_cnt_reg[g] <= soft_cnt_reg[g] - SOFT_W'(1);
        end
      end

      // effective settings: straps or register fields
      assign cfg_next[g].duty_fix_disable = ~par_s & fmt[amc_pkg::FMT_DUTY_BIT];
      assign cfg_next[g].scramble_enable = ~par_s & fmt[amc_pkg::FMT_SCRAMBLE_BIT];
      assign cfg_next[g].signed_format = ~par_s & fmt[amc_pkg::FMT_SIGNED_BIT];
      assign cfg_next[g].sleep = par_s ? sdi_s :
                                 (fmt[amc_pkg::FMT_SLEEP_BIT] | soft_sleep);
      assign cfg_next[g].nap = par_s ? 4'h0 : fmt[amc_pkg::FMT_NAP_MSB:0];
      assign cfg_next[g].drive_current_10ua = term ? {cur_base[8:0], 1'b0} : cur_base;
      assign cfg_next[g].internal_load_enable = term;
      assign cfg_next[g].driver_disable = ~par_s & om[amc_pkg::OM_OFF_BIT];
      assign cfg_next[g].lane_width_select = lane;
      assign cfg_next[g].two_lane = ~lane[2];
      assign cfg_next[g].serial_bits = amc_pkg::amc_serial_bits(lane);
      assign cfg_next[g].pattern_force = ~par_s & phi[amc_pkg::PAT_FORCE_BIT];
      assign cfg_next[g].pattern_value = {phi[amc_pkg::PAT_HI_MSB:0], plo};
    end
  endgenerate

  // registered settings
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign group_cfg_o = cfg_reg;

  // ****************************************
  // per-channel data and wake timing
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < amc_pkg::NUM_CH; c++) begin : g_ch
      localparam int GRP = amc_pkg::CH_IN_GROUP_TWO[c] ? 1 : 0;
      logic [13:0] fmt_data;
      logic [13:0] data_reg;
      logic [WAKE_W-1:0] wake_reg;
      logic ready_reg;
      wire asleep = cfg_reg[GRP].sleep;
      wire napped = cfg_reg[GRP].nap[c / 2];

      amc_format u_fmt (
        .code_i(adc_code_i[c]),
        .signed_i(cfg_reg[GRP].signed_format),
        .scramble_i(cfg_reg[GRP].scramble_enable),
        .force_i(cfg_reg[GRP].pattern_force),
        .pattern_i(cfg_reg[GRP].pattern_value),
        .data_o(fmt_data)
      );

      // recovery count restarts while the channel is down
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          data_reg <= '0;
          wake_reg <= '0;
          ready_reg <= 1'b0;
        end else begin
          data_reg <= fmt_data;
          if (asleep) begin
            wake_reg <= WAKE_W'(SLEEP_RECOVER_CYCLES);
          end else if (napped) begin
            wake_reg <= WAKE_W'(NAP_RECOVER_CYCLES);
          end else if (wake_reg != '0) begin
            wake_reg <= wake_reg - WAKE_W'(1);
          end
          ready_reg <= ~asleep & ~napped & (wake_reg == '0);
        end
      end

      assign data_o[c] = data_reg;
      assign channel_ready_o[c] = ready_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// file: design/amc_pkg.sv
`default_nettype none
package amc_pkg;
  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int CODE_W = 14;
  localparam int NUM_CH = 8;
  localparam int NUM_GRP = 2;
  localparam int NUM_MODE = 4;
  localparam int FRAME_BITS = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEEP_RECOVER_NS = 2000000;
  localparam int SLEEP_RECOVER_CYCLES =
    (SLEEP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NAP_RECOVER_CYCLES = 100;
  localparam int SOFT_SLEEP_CYCLES = 16;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT = 7'h01;
  localparam logic [6:0] ADDR_OUTMODE = 7'h02;
  localparam logic [6:0] ADDR_PAT_HI = 7'h03;
  localparam logic [6:0] ADDR_PAT_LO = 7'h04;
  localparam logic [1:0] IDX_FORMAT = 2'h0;
  localparam logic [1:0] IDX_OUTMODE = 2'h1;
  localparam logic [1:0] IDX_PAT_HI = 2'h2;
  localparam logic [1:0] IDX_PAT_LO = 2'h3;
  localparam logic [7:0] MODE_RESET_VAL = 8'h00;
  localparam int RESET_BIT = 7;
  localparam int FMT_DUTY_BIT = 7;
  localparam int FMT_SCRAMBLE_BIT = 6;
  localparam int FMT_SIGNED_BIT = 5;
  localparam int FMT_SLEEP_BIT = 4;
  localparam int FMT_NAP_MSB = 3;
  localparam int OM_CUR_MSB = 7;
  localparam int OM_CUR_LSB = 5;
  localparam int OM_TERM_BIT = 4;
  localparam int OM_OFF_BIT = 3;
  localparam int OM_LANE_MSB = 2;
  localparam int PAT_FORCE_BIT = 7;
  localparam int PAT_HI_MSB = 5;
  // bit set: channel belongs to the second register set
  localparam logic [7:0] CH_IN_GROUP_TWO = 8'h66;

  // ****************************************
  // codes
  // ****************************************
  localparam logic [2:0] LANE_2_16 = 3'h0;
  localparam logic [2:0] LANE_1_14 = 3'h5;
  localparam logic [2:0] CUR_3P5 = 3'h0;
  localparam logic [2:0] CUR_1P75 = 3'h7;

  typedef struct packed {
    logic duty_fix_disable;
    logic scramble_enable;
    logic signed_format;
    logic sleep;
    logic [3:0] nap;
    logic [9:0] drive_current_10ua;
    logic internal_load_enable;
    logic driver_disable;
    logic [2:0] lane_width_select;
    logic two_lane;
    logic [4:0] serial_bits;
    logic pattern_force;
    logic [13:0] pattern_value;
  } amc_cfg_s;

  // driver current in units of 10 uA; unused code keeps the default
  function automatic logic [9:0] amc_current(input logic [2:0] code);
    case (code)
      3'h0: amc_current = 10'h15e;
      3'h1: amc_current = 10'h190;
      3'h2: amc_current = 10'h1c2;
      3'h4: amc_current = 10'h12c;
      3'h5: amc_current = 10'h0fa;
      3'h6: amc_current = 10'h0d2;
      3'h7: amc_current = 10'h0af;
      default: amc_current = 10'h15e;
    endcase
  endfunction

  // serialization width; zero marks an unused code
  function automatic logic [4:0] amc_serial_bits(input logic [2:0] code);
    case (code)
      3'h0: amc_serial_bits = 5'h10;
      3'h1: amc_serial_bits = 5'h0e;
      3'h2: amc_serial_bits = 5'h0c;
      3'h5: amc_serial_bits = 5'h0e;
      3'h6: amc_serial_bits = 5'h0c;
      3'h7: amc_serial_bits = 5'h10;
      default: amc_serial_bits = 5'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: design/amc_sync.sv
`default_nettype none
// two-stage synchroniser for pin levels
module amc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: design/amc_format.sv
`default_nettype none
// per-channel output word coding
module amc_format (
  input wire logic [13:0] code_i,
  input wire logic signed_i,
  input wire logic scramble_i,
  input wire logic force_i,
  input wire logic [13:0] pattern_i,
  output logic [13:0] data_o
);
  logic [13:0] coded;
  logic [13:0] mixed;

  // top bit inverted gives two's complement
  assign coded = {code_i[13] ^ signed_i, code_i[12:0]};
  // lsb folded into every other bit
  assign mixed = scramble_i ? {coded[13:1] ^ {13{coded[0]}}, coded[0]} : coded;
  // forced pattern wins over all coding
  assign data_o = force_i ? pattern_i : mixed;
endmodule
`default_nettype wire

// file: dv/amc_mode_control_port_asserts.sv
`default_nettype none
module amc_mode_control_port_asserts #(
  parameter int SLEEP_RECOVER_CYCLES = 20,
  parameter int NAP_RECOVER_CYCLES = 100,
  parameter int SOFT_SLEEP_CYCLES = 16
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic port_style_select_i,
  input wire logic group_one_select_n_i,
  input wire logic group_two_select_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic sdo_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic [7:0][13:0] adc_code_i,
  input wire logic [7:0][13:0] data_o,
  input wire amc_pkg::amc_cfg_s [1:0] group_cfg_o,
  input wire logic [7:0] channel_ready_o
);
  // ****
  // helpers
  // ****
  logic [1:0] armed_reg;
  default clocking @(posedge mclk_i); endclocking
  // settings read as zero until the first load after reset
  default disable iff (!resetn_i || !armed_reg[1]);
  logic [15:0] quiet_reg;
  logic down_reg;

  // two edges after reset release the registered settings are valid
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_reg <= 2'h0;
    end else begin
      armed_reg <= {armed_reg[0], 1'b1};
    end
  end

  // expected output word: coding, then scramble, pattern overrides both
  function automatic logic [13:0] want(input logic [13:0] c, input amc_pkg::amc_cfg_s k);
    logic [13:0] w;
    w = k.signed_format ? {~c[13], c[12:0]} : c;
    if (k.scramble_enable) w = {w[13:1] ^ {13{w[0]}}, w[0]};
    want = k.pattern_force ? k.pattern_value : w;
  endfunction

  // cycles of channel one awake since its last nap or sleep
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quiet_reg <= 16'h0;
      down_reg <= 1'b0;
    end else if (group_cfg_o[0].nap[0] || group_cfg_o[0].sleep) begin
      quiet_reg <= 16'h0;
      down_reg <= 1'b1;
    end else if (quiet_reg != 16'hffff) begin
      quiet_reg <= quiet_reg + 16'h1;
    end
  end

  // ****
  // sequences and assertions
  // ****
  sequence s_idle;
    (port_style_select_i || (group_one_select_n_i && group_two_select_n_i)) [*6];
  endsequence
  sequence s_steady(ch, g);
    ($stable(adc_code_i[ch]) && $stable(group_cfg_o[g])) [*3];
  endsequence
  sequence s_strap;
    (port_style_select_i && $stable({group_one_select_n_i, sclk_i, sdata_i, sdo_i})) [*6];
  endsequence

  a_sdo_pull_low: assert property (sdo_o == 1'b0)
    else $error("data-out drives high");
  a_idle_release: assert property (s_idle |-> sdo_oe_n_o)
    else $error("data-out pulled outside a frame");
  a_term_current: assert property (group_cfg_o[0].internal_load_enable ?
    group_cfg_o[0].drive_current_10ua inside {10'h2bc, 10'h320, 10'h384, 10'h258,
      10'h1f4, 10'h1a4, 10'h15e} :
    group_cfg_o[0].drive_current_10ua inside {10'h15e, 10'h190, 10'h1c2, 10'h12c,
      10'h0fa, 10'h0d2, 10'h0af}) else $error("driver current wrong");
  a_lane_decode: assert property (group_cfg_o[1].serial_bits ==
    (group_cfg_o[1].lane_width_select inside {3'h0, 3'h7} ? 5'h10 :
     group_cfg_o[1].lane_width_select inside {3'h1, 3'h5} ? 5'h0e :
     group_cfg_o[1].lane_width_select inside {3'h2, 3'h6} ? 5'h0c : 5'h00))
    else $error("serialization width wrong");
  a_fmt_set_one: assert property (s_steady(0, 0) |->
    data_o[0] == want(adc_code_i[0], group_cfg_o[0])) else $error("channel 1 word wrong");
  a_fmt_set_two: assert property (s_steady(1, 1) |->
    data_o[1] == want(adc_code_i[1], group_cfg_o[1])) else $error("channel 2 word wrong");
  a_sleep_ready: assert property (group_cfg_o[1].sleep [*2] |->
    (channel_ready_o & 8'h66) == 8'h00) else $error("set two ready in sleep");
  a_nap_ready: assert property (group_cfg_o[0].nap[0] [*2] |-> !channel_ready_o[0])
    else $error("channel 1 ready in nap");
  a_nap_wake: assert property ($rose(channel_ready_o[0]) && down_reg |->
    quiet_reg >= NAP_RECOVER_CYCLES - 1) else $error("channel 1 woke too early");
  a_strap_map: assert property (s_strap |->
    group_cfg_o[0].two_lane == !group_one_select_n_i && group_cfg_o[0].sleep == sdata_i &&
    group_cfg_o[0].internal_load_enable == sdo_i &&
    group_cfg_o[0].drive_current_10ua == ((sclk_i ? 10'h0af : 10'h15e) << sdo_i))
    else $error("strap settings wrong");
endmodule

bind amc_mode_control_port amc_mode_control_port_asserts #(
  .SLEEP_RECOVER_CYCLES(SLEEP_RECOVER_CYCLES),
  .NAP_RECOVER_CYCLES(NAP_RECOVER_CYCLES),
  .SOFT_SLEEP_CYCLES(SOFT_SLEEP_CYCLES)
) u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .port_style_select_i(port_style_select_i),
  .group_one_select_n_i(group_one_select_n_i), .group_two_select_n_i(group_two_select_n_i),
  .sclk_i(sclk_i), .sdata_i(sdata_i), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
  .adc_code_i(adc_code_i), .data_o(data_o), .group_cfg_o(group_cfg_o),
  .channel_ready_o(channel_ready_o));
`default_nettype wire

// file: dv/amc_host_model.sv
`default_nettype none
module amc_host_model (
  input wire logic mclk_i,
  input wire logic sdo_line_i,
  output logic [1:0] sel_n_o,
  output logic sclk_o,
  output logic sdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // host side of the serial port
  // ****
  // link idle: selects high, clock still
  initial begin
    sel_n_o = 2'b11;
    sclk_o = 1'b0;
    sdata_o = 1'b0;
  end

  // one frame of n clock rises; read bits sampled before each late rise
  task automatic xfer(input logic [1:0] sel, input logic [15:0] cmd, input int n,
                      output logic [7:0] rd);
    logic b;
    rd = 8'h00;
    @(posedge mclk_i);
    sel_n_o <= sel;
    for (int i = 0; i < n; i++) begin
      b = (i < 16) ? cmd[15-i] : 1'b1;
      sdata_o <= b;
      repeat (4) @(posedge mclk_i);
      if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b0;
    end
    sdata_o <= ~b;
    repeat (4) @(posedge mclk_i);
    sel_n_o <= 2'b11;
    repeat (8) @(posedge mclk_i);
  endtask

  // static pin levels for the strapped mode
  task automatic strap(input logic s1, input logic sck, input logic sdi);
    @(posedge mclk_i);
    sel_n_o <= {1'b1, s1};
    sclk_o <= sck;
    sdata_o <= sdi;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_adc_mode_control_port.sv
`default_nettype none
module tb_adc_mode_control_port;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
  // ****
  // bench signals
  // ****
  typedef struct packed {
    logic [1:0] sel_n;
    logic [6:0] addr;
    logic [7:0] wr;
    logic [7:0] rd;
  } amc_row_s;
  logic mclk, resetn, style, strap_sdo, sclk, sdata, sdo_o, sdo_oe_n_o;
  logic [1:0] sel_n;
  logic [7:0] cyc, channel_ready_o;
  logic [7:0][13:0] adc, data_o;
  amc_pkg::amc_cfg_s [1:0] group_cfg_o;
  wire logic sdo_line;
  int miscompares = 0;
  int total_checks = 0;
  logic [13:0] vals [4] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1555};
  logic [9:0] cur [8] = '{10'h15e, 10'h190, 10'h1c2, 10'h15e, 10'h12c, 10'h0fa, 10'h0d2, 10'h0af};
  logic [4:0] lanes [8] = '{5'h10, 5'h0e, 5'h0c, 5'h00, 5'h00, 5'h0e, 5'h0c, 5'h10};
  amc_row_s rows [9] = '{'{2'b10, 7'h01, 8'h6f, 8'h6f}, '{2'b01, 7'h01, 8'h11, 8'h11},
    '{2'b10, 7'h03, 8'ha5, 8'ha5}, '{2'b10, 7'h04, 8'h3c, 8'h3c}, '{2'b01, 7'h02, 8'hf5, 8'hf5},
    '{2'b00, 7'h05, 8'h77, 8'h00}, '{2'b00, 7'h00, 8'h00, 8'h00}, '{2'b10, 7'h03, 8'h00, 8'h00},
    '{2'b00, 7'h01, 8'h00, 8'h00}};

  // open-drain line with pull-up, or the strap level
  assign sdo_line = style ? strap_sdo : (sdo_oe_n_o ? 1'b1 : sdo_o);

  amc_mode_control_port #(.SLEEP_RECOVER_CYCLES(120), .NAP_RECOVER_CYCLES(100),
    .SOFT_SLEEP_CYCLES(16)) DUT (.mclk_i(mclk), .resetn_i(resetn), .port_style_select_i(style),
    .group_one_select_n_i(sel_n[0]), .group_two_select_n_i(sel_n[1]), .sclk_i(sclk),
    .sdata_i(sdata), .sdo_i(sdo_line), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .adc_code_i(adc), .data_o(data_o), .group_cfg_o(group_cfg_o),
    .channel_ready_o(channel_ready_o));
  amc_host_model u_host (.mclk_i(mclk), .sdo_line_i(sdo_line), .sel_n_o(sel_n),
    .sclk_o(sclk), .sdata_o(sdata));

  // clock and converter codes stepping through boundary values
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 8'h1;
    for (int c = 0; c < 8; c++) adc[c] <= vals[2'(cyc[5:4] + c)];
  end

  // verdict
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [7:0] rd;
    resetn = 1'b0;
    style = 1'b0;
    strap_sdo = 1'b0;
    cyc = 8'h0;
    adc = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(sdo_oe_n_o, 1'b1)
    `CHK(group_cfg_o[0].drive_current_10ua, 10'h15e)
    foreach (rows[i]) begin
      u_host.xfer(rows[i].sel_n, {1'b0, rows[i].addr, rows[i].wr}, 16, rd);
      u_host.xfer(rows[i].sel_n, {1'b1, rows[i].addr, 8'h5a}, 16, rd);
      `CHK(rd, rows[i].rd)
    end
    repeat (150) @(posedge mclk);
    `CHK(channel_ready_o, 8'hff)
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(2'b00, {1'b0, 7'h02, i[2:0], 1'b0, i[0], i[2:0]}, 16, rd);
      `CHK(group_cfg_o[1].drive_current_10ua, cur[i])
      `CHK(group_cfg_o[0].serial_bits, lanes[i])
      `CHK(group_cfg_o[0].driver_disable, i[0])
    end
    // extra rises ignored, short frame dropped
    u_host.xfer(2'b10, {1'b0, 7'h04, 8'h81}, 18, rd);
    u_host.xfer(2'b10, {1'b0, 7'h04, 8'h18}, 8, rd);
    u_host.xfer(2'b10, {1'b1, 7'h04, 8'h00}, 16, rd);
    `CHK(rd, 8'h81)
    // soft reset of set one leaves set two alone
    u_host.xfer(2'b10, {1'b0, 7'h00, 8'h80}, 16, rd);
    u_host.xfer(2'b10, {1'b1, 7'h02, 8'h00}, 16, rd);
    `CHK(rd, 8'h00)
    u_host.xfer(2'b01, {1'b1, 7'h02, 8'h00}, 16, rd);
    `CHK(rd, 8'hef)
    // strapped mode
    u_host.strap(1'b0, 1'b1, 1'b0);
    strap_sdo <= 1'b1;
    style <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK(group_cfg_o[1].two_lane, 1'b1)
    `CHK(group_cfg_o[0].drive_current_10ua, 10'h15e)
    u_host.strap(1'b1, 1'b0, 1'b1);
    strap_sdo <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK(group_cfg_o[0].serial_bits, 5'h0e)
    `CHK(group_cfg_o[0].sleep, 1'b1)
    end_of_test();
  end
endmodule
`default_nettype wire
